// ==== rtl/dnac_top.sv ====
// Data NVM access, unlock and protection logic with APB register slave
//
// The APB slave port and the register offsets are this design's own decisions.
`include "dnac_defs.svh"
`default_nettype none

// Notes on behaviour
// RL1 - Either protect setting blocks external programmer access
// RL2 - Internal CPU access ignores protect settings
// RL3 - Location register selects one byte
// RL4 - Location and byte registers clear on resets
// RL5 - Key port stores nothing, feeds detector
// RL6 - Write starts only after 55h, AAh, trigger
// RL7 - Commit bit stays set until write completes
// RL8 - Control reset: defined bits zero, others kept
// RL9 - Software refreshes array when endurance demands
// RL10 - Fetch loads byte register, then self-clears
// RL11 - Software masks interrupts around key sequence
module dnac_top
    import dnac_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DEPTH = 256,
    parameter int WRITE_CYCLES = `DNAC_WRITE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic protect_a,
    input wire logic protect_b,
    input wire logic prog_valid,
    input wire logic prog_write,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    output logic prog_ready,
    output logic [7:0] prog_rdata,
    output logic prog_refused,
    output logic write_busy
);
    import dnac_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

    generate
        if (ADDR_W < 1 || ADDR_W > 8 || DEPTH > (1 << ADDR_W) || DEPTH < 2) begin : g_bad_depth
            $error("dnac_top: DEPTH must fit the 8-bit location register");
        end
        if (WRITE_CYCLES < 1) begin : g_bad_cycles
            $error("dnac_top: WRITE_CYCLES must be at least one");
        end
    endgenerate

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] mem [0:DEPTH-1]; // Byte array, no reset
    logic [7:0] location_reg; // Selected byte
    logic [7:0] byte_reg; // Data byte
    logic flash_sel_reg; // Space select, kept over soft reset
    logic fuse_sel_reg; // Space select, kept over soft reset
    logic erase_sel_reg; // Stored option bit
    logic abort_reg; // Write aborted by soft reset, kept over soft reset
    logic permit_reg; // Write permit
    logic busy_reg; // Commit trigger bit, write in progress
    logic fetch_reg; // Fetch trigger bit
    logic [CNT_W-1:0] cnt_reg; // Cycles left in the write
    logic [ADDR_W-1:0] commit_addr_reg; // Latched write target
    logic [7:0] commit_data_reg; // Latched write data
    dnac_key_state_t key_reg; // Unlock detector
    logic [31:0] prdata_reg; // Read data captured before access end
    logic err_reg; // Unmapped address flag
    logic data_ok_reg; // Read data captured for this transfer
    logic [7:0] prog_rdata_reg; // Programmer read data
    logic prog_refused_reg; // Programmer access refused

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic mapped; // Address hits a register
    logic apb_wr; // Write takes effect this edge
    logic wr_loc, wr_byte, wr_key, wr_ctrl; // Per-register write strobes
    logic ctrl_start; // Commit trigger write arriving
    logic commit_go; // Write really starts
    logic protected_now; // Either protect setting active
    logic prog_take; // Programmer request served this edge
    logic [7:0] ctrl_view; // Control register as read
    logic [ADDR_W-1:0] loc_idx; // Array index from location

    assign mapped = (paddr == `DNAC_OFF_LOCATION) || (paddr == `DNAC_OFF_BYTE) ||
                    (paddr == `DNAC_OFF_KEY) || (paddr == `DNAC_OFF_CTRL);
    assign pready = psel && penable && ce && data_ok_reg;
    assign pslverr = pready && err_reg;
    assign prdata = prdata_reg;
    assign apb_wr = pready && pwrite && mapped && pstrb[0];
    assign wr_loc = apb_wr && (paddr == `DNAC_OFF_LOCATION);
    assign wr_byte = apb_wr && (paddr == `DNAC_OFF_BYTE);
    assign wr_key = apb_wr && (paddr == `DNAC_OFF_KEY);
    assign wr_ctrl = apb_wr && (paddr == `DNAC_OFF_CTRL);
    assign ctrl_start = wr_ctrl && pwdata[`DNAC_BIT_COMMIT];
    // Start needs the armed key, permit already set, and space set to data array
    assign commit_go = ctrl_start && (key_reg == KEY_ARMED) && permit_reg && !busy_reg &&
                       !flash_sel_reg && !fuse_sel_reg && !soft_reset; // [RL6]
    assign protected_now = protect_a || protect_b;
    assign prog_take = prog_valid && ce && !busy_reg && !soft_reset;
    assign prog_ready = prog_take;
    assign prog_rdata = prog_rdata_reg;
    assign prog_refused = prog_refused_reg;
    assign write_busy = busy_reg;
    assign loc_idx = location_reg[ADDR_W-1:0]; // [RL3]
    assign ctrl_view = {flash_sel_reg, fuse_sel_reg, 1'b0, erase_sel_reg,
                        abort_reg, permit_reg, busy_reg, fetch_reg};

    // ****************************************************************
    // APB read capture
    // ****************************************************************
    // Read data is taken one ce cycle into the transfer so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            data_ok_reg <= 1'b0;
        end else if (ce) begin
            data_ok_reg <= psel && !pready;
            err_reg <= !mapped;
            if (psel && !pready) begin
                unique case (paddr)
                    `DNAC_OFF_LOCATION: prdata_reg <= {24'h00_0000, location_reg};
                    `DNAC_OFF_BYTE: prdata_reg <= {24'h00_0000, byte_reg};
                    `DNAC_OFF_CTRL: prdata_reg <= {24'h00_0000, ctrl_view};
                    // Key port has no storage and reads zero
                    default: prdata_reg <= 32'h0000_0000; // [RL5]
                endcase
            end
        end
    end

    // ****************************************************************
    // Location and byte registers
    // ****************************************************************
    // Both clear on power-on and on soft reset; fetch reloads the byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            location_reg <= `DNAC_LOCATION_RST; // [RL4]
            byte_reg <= `DNAC_BYTE_RST; // [RL4]
        end else if (ce) begin
            if (soft_reset) begin
                location_reg <= `DNAC_LOCATION_RST; // [RL4]
                byte_reg <= `DNAC_BYTE_RST; // [RL4]
            end else begin
                if (wr_loc) begin
                    location_reg <= pwdata[7:0];
                end
                // Fetch wins over a same-cycle byte write
                if (fetch_reg) begin
                    byte_reg <= mem[loc_idx]; // [RL10] [RL2]
                end else if (wr_byte) begin
                    byte_reg <= pwdata[7:0];
                end
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Soft reset keeps space selects, keeps the abort flag or sets it if a write runs, clears the rest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_sel_reg <= 1'b0; // [RL8]
            fuse_sel_reg <= 1'b0; // [RL8]
            erase_sel_reg <= 1'b0; // [RL8]
            abort_reg <= 1'b0; // [RL8]
            permit_reg <= 1'b0; // [RL8]
            fetch_reg <= 1'b0; // [RL8]
        end else if (ce) begin
            if (soft_reset) begin
                erase_sel_reg <= 1'b0; // [RL8]
                permit_reg <= 1'b0; // [RL8]
                fetch_reg <= 1'b0; // [RL8]
                // An interrupted write is reported
                if (busy_reg) begin
                    abort_reg <= 1'b1;
                end
            end else begin
                if (wr_ctrl) begin
                    flash_sel_reg <= pwdata[`DNAC_BIT_FLASH_SEL];
                    fuse_sel_reg <= pwdata[`DNAC_BIT_FUSE_SEL];
                    erase_sel_reg <= pwdata[`DNAC_BIT_ERASE_SEL];
                    permit_reg <= pwdata[`DNAC_BIT_PERMIT];
                    // Software may only clear the abort flag
                    if (!pwdata[`DNAC_BIT_ABORT]) begin
                        abort_reg <= 1'b0;
                    end
                end
                // Fetch arms for one cycle, then clears itself
                if (fetch_reg) begin
                    fetch_reg <= 1'b0; // [RL10]
                end else if (wr_ctrl && pwdata[`DNAC_BIT_FETCH] &&
                             !flash_sel_reg && !fuse_sel_reg) begin
                    fetch_reg <= 1'b1; // [RL10]
                end
            end
        end
    end

    // ****************************************************************
    // Unlock sequence detector
    // ****************************************************************
    // Any other register write between the keys breaks the sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= KEY_IDLE;
        end else if (ce) begin
            if (soft_reset) begin
                key_reg <= KEY_IDLE;
            end else if (wr_key) begin
                unique case (key_reg)
                    KEY_IDLE: key_reg <= (pwdata[7:0] == `DNAC_KEY_FIRST) ?
                                         KEY_GOT_FIRST : KEY_IDLE; // [RL6] [RL5]
                    KEY_GOT_FIRST: key_reg <= (pwdata[7:0] == `DNAC_KEY_SECOND) ? KEY_ARMED :
                        ((pwdata[7:0] == `DNAC_KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE); // [RL6]
                    KEY_ARMED: key_reg <= (pwdata[7:0] == `DNAC_KEY_FIRST) ?
                                          KEY_GOT_FIRST : KEY_IDLE; // [RL6]
                endcase
            end else if (apb_wr) begin
                key_reg <= KEY_IDLE; // [RL6]
            end
        end
    end

    // ****************************************************************
    // Write timer and commit trigger
    // ****************************************************************
    // Trigger stays high for the whole write; only hardware clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'b0; // [RL8]
            cnt_reg <= '0;
            commit_addr_reg <= '0;
            commit_data_reg <= 8'h00;
        end else if (ce) begin
            if (soft_reset) begin
                busy_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (commit_go) begin
                busy_reg <= 1'b1; // [RL7]
                cnt_reg <= CNT_LOAD;
                commit_addr_reg <= loc_idx; // [RL3]
                commit_data_reg <= byte_reg;
            end else if (busy_reg) begin
                if (cnt_reg == '0) begin
                    busy_reg <= 1'b0; // [RL7]
                end else begin
                    cnt_reg <= cnt_reg - CNT_W'(1);
                end
            end
        end
    end

    // ****************************************************************
    // Array writes and programmer port
    // ****************************************************************
    // Programmer is only served while no internal write runs
    always_ff @(posedge pclk) begin
        if (ce && !soft_reset) begin
            if (busy_reg && cnt_reg == '0) begin
                mem[commit_addr_reg] <= commit_data_reg; // [RL2]
            end else if (prog_take && prog_write && !protected_now) begin
                mem[prog_addr] <= prog_wdata; // [RL1]
            end
        end
    end

    // Programmer answers: refused when protected, read data zero then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_rdata_reg <= 8'h00;
            prog_refused_reg <= 1'b0;
        end else if (ce) begin
            prog_refused_reg <= prog_take && protected_now; // [RL1]
            if (prog_take) begin
                prog_rdata_reg <= (protected_now || prog_write) ? 8'h00 : mem[prog_addr]; // [RL1]
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_prog_blocked: assert property (prog_take && protected_now |=> // [RL1]
        prog_refused && prog_rdata == 8'h00)
        else $error("protected programmer access not refused");
    a_cpu_ignores_cp: assert property (ce && commit_go && protected_now |=> busy_reg) // [RL2]
        else $error("protect setting blocked internal write");
    a_commit_target: assert property (ce && commit_go |=> // [RL3]
        commit_addr_reg == $past(loc_idx) && commit_data_reg == $past(byte_reg))
        else $error("write target not latched from location");
    a_soft_clear: assert property (ce && soft_reset |=> // [RL4]
        location_reg == 8'h00 && byte_reg == 8'h00)
        else $error("soft reset did not clear registers");
    a_key_reads_zero: assert property (pready && !pwrite && paddr == `DNAC_OFF_KEY |-> // [RL5]
        prdata == 32'h0000_0000)
        else $error("key port read not zero");
    a_no_unarmed_start: assert property (ce && !busy_reg && key_reg != KEY_ARMED |=> // [RL6]
        !busy_reg)
        else $error("write started without unlock");
    a_key_sequence: assert property (ce && wr_key && key_reg == KEY_GOT_FIRST && // [RL6]
        pwdata[7:0] == `DNAC_KEY_SECOND |=> key_reg == KEY_ARMED)
        else $error("second key did not arm");
    a_busy_holds: assert property (busy_reg && (cnt_reg != '0 || !ce) && !soft_reset // [RL7]
        |=> busy_reg)
        else $error("commit bit dropped early");
    a_busy_ends: assert property (ce && busy_reg && cnt_reg == '0 && !soft_reset |=> // [RL7]
        !busy_reg && mem[commit_addr_reg] == commit_data_reg)
        else $error("write did not complete");
    a_ctrl_soft: assert property (ce && soft_reset |=> ctrl_view[2:0] == 3'h0 && // [RL8]
        !erase_sel_reg && flash_sel_reg == $past(flash_sel_reg) &&
        fuse_sel_reg == $past(fuse_sel_reg))
        else $error("control soft reset wrong");
    a_fetch_clears: assert property (ce && fetch_reg && !soft_reset |=> // [RL10]
        !fetch_reg && byte_reg == $past(mem[loc_idx]))
        else $error("fetch did not load and clear");

    c_commit: cover property (ce && commit_go ##[1:200] !busy_reg);
    c_fetch: cover property (ce && fetch_reg);
    c_refused: cover property (prog_take && protected_now);
    c_abort: cover property (ce && soft_reset && busy_reg);
endmodule
`default_nettype wire

// ==== rtl/dnac_defs.svh ====
// Register offsets, field positions, key values and reset values of the data NVM access block
`ifndef DNAC_DEFS_SVH
`define DNAC_DEFS_SVH

// ****************************************************************
// Register byte offsets on APB
// ****************************************************************
`define DNAC_OFF_LOCATION 12'h000
`define DNAC_OFF_BYTE 12'h004
`define DNAC_OFF_KEY 12'h008
`define DNAC_OFF_CTRL 12'h00c

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define DNAC_BIT_FLASH_SEL 7
`define DNAC_BIT_FUSE_SEL 6
`define DNAC_BIT_ERASE_SEL 4
`define DNAC_BIT_ABORT 3
`define DNAC_BIT_PERMIT 2
`define DNAC_BIT_COMMIT 1
`define DNAC_BIT_FETCH 0

// ****************************************************************
// Unlock key values and reset values
// ****************************************************************
`define DNAC_KEY_FIRST 8'h55
`define DNAC_KEY_SECOND 8'haa
`define DNAC_LOCATION_RST 8'h00
`define DNAC_BYTE_RST 8'h00
`define DNAC_WRITE_CYCLES 64

`endif

// ==== rtl/dnac_pkg.sv ====
// Types shared by the data NVM access block
`default_nettype none
package dnac_pkg;
    // Progress of the two-value unlock sequence
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } dnac_key_state_t;
endpackage
`default_nettype wire

// ==== tb/dnac_top_tb.sv ====
// Self-checking testbench for the data NVM access block
`include "dnac_defs.svh"
`default_nettype none

module dnac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dnac_pkg::*;

    // ****************************************************************
    // Signals, counters and the design
    // ****************************************************************
    localparam int WC = 8; // Shortened write time keeps the run brief
    logic pclk, presetn, ce, soft_reset, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, er, protect_a, protect_b, prog_valid, prog_write;
    logic [7:0] prog_addr, prog_wdata, prog_rdata, prd;
    logic prog_ready, prog_refused, prf, write_busy;
    int err_total, n_tests, cyc, busy_cyc;

    dnac_top #(.ADDR_W(8), .DEPTH(256), .WRITE_CYCLES(WC)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .soft_reset(soft_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .protect_a(protect_a), .protect_b(protect_b),
        .prog_valid(prog_valid), .prog_write(prog_write), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_ready(prog_ready), .prog_rdata(prog_rdata),
        .prog_refused(prog_refused), .write_busy(write_busy));

    // Clock, cycle ceiling and busy-length count
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (write_busy === 1'b1) begin
            busy_cyc++;
        end
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, entered just after a rising edge, one idle cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No timeout of its own; pready ends this wait, the bench's cycle ceiling ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, {24'h0, exp}, rd);
    endtask

    // Full unlock sequence followed by the commit trigger
    task automatic commit(input logic [7:0] loc, input logic [7:0] dat);
        wr(`DNAC_OFF_LOCATION, loc);
        wr(`DNAC_OFF_BYTE, dat);
        wr(`DNAC_OFF_CTRL, 8'h04);
        busy_cyc = 0;
        wr(`DNAC_OFF_KEY, `DNAC_KEY_FIRST);
        wr(`DNAC_OFF_KEY, `DNAC_KEY_SECOND);
        wr(`DNAC_OFF_CTRL, 8'h06);
    endtask

    // Fetch one byte through the CPU path and compare it
    task automatic fetch(input logic [7:0] loc, input logic [7:0] exp);
        wr(`DNAC_OFF_LOCATION, loc);
        wr(`DNAC_OFF_BYTE, 8'h00);
        wr(`DNAC_OFF_CTRL, 8'h01);
        rdchk("fetched_byte", `DNAC_OFF_BYTE, exp);
        rdchk("fetch_cleared", `DNAC_OFF_CTRL, 8'h00);
    endtask

    // One programmer request; answer captured a cycle after the take
    task automatic prog(input logic w, input logic [7:0] a, input logic [7:0] d);
        prog_valid <= 1'b1;
        prog_write <= w;
        prog_addr <= a;
        prog_wdata <= d;
        do begin
            @(posedge pclk);
        end while (prog_ready !== 1'b1);
        prog_valid <= 1'b0;
        // Answer stands during the cycle after the take
        @(posedge pclk);
        prd = prog_rdata;
        prf = prog_refused;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values, key port without storage, unmapped address
    task automatic t_reset();
        rdchk("location_rst", `DNAC_OFF_LOCATION, `DNAC_LOCATION_RST);
        rdchk("byte_rst", `DNAC_OFF_BYTE, `DNAC_BYTE_RST);
        rdchk("ctrl_rst", `DNAC_OFF_CTRL, 8'h00);
        wr(`DNAC_OFF_KEY, `DNAC_KEY_FIRST);
        rdchk("key_reads_zero", `DNAC_OFF_KEY, 8'h00);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        $display("t_reset done");
    endtask

    // CPU write while both protections are on, busy polling, fetch back
    task automatic t_commit();
        protect_a <= 1'b1;
        protect_b <= 1'b1;
        commit(8'h12, 8'h5a);
        chk("busy_set", 32'h1, {31'h0, write_busy});
        rdchk("ctrl_busy", `DNAC_OFF_CTRL, 8'h06);
        // Clock enable low for three cycles freezes the write timer
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        while (write_busy === 1'b1 && cyc < 19000) begin
            @(posedge pclk);
        end
        chk("busy_len", WC + 3, busy_cyc);
        rdchk("ctrl_done", `DNAC_OFF_CTRL, 8'h04);
        fetch(8'h12, 8'h5a);
        // Refresh: rewrite the byte just fetched, polling the trigger bit
        wr(`DNAC_OFF_CTRL, 8'h04);
        wr(`DNAC_OFF_KEY, `DNAC_KEY_FIRST);
        wr(`DNAC_OFF_KEY, `DNAC_KEY_SECOND);
        wr(`DNAC_OFF_CTRL, 8'h06);
        chk("refresh_busy", 32'h1, {31'h0, write_busy});
        while (write_busy === 1'b1 && cyc < 19000) begin
            @(posedge pclk);
        end
        fetch(8'h12, 8'h5a);
        protect_a <= 1'b0;
        protect_b <= 1'b0;
        $display("t_commit done");
    endtask

    // Broken unlock sequences, or a correct one without permit set, must not start a write
    task automatic t_keys();
        logic [7:0] k1 [3] = '{8'haa, 8'h55, 8'h55};
        logic [7:0] k2 [3] = '{8'h55, 8'haa, 8'haa};
        logic [7:0] pre [3] = '{8'h04, 8'h04, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(`DNAC_OFF_LOCATION, 8'h12);
            wr(`DNAC_OFF_BYTE, 8'h99);
            wr(`DNAC_OFF_CTRL, pre[i]);
            wr(`DNAC_OFF_KEY, k1[i]);
            if (i == 1) begin
                wr(`DNAC_OFF_LOCATION, 8'h12);
            end
            wr(`DNAC_OFF_KEY, k2[i]);
            wr(`DNAC_OFF_CTRL, 8'h06);
            chk("no_start", 32'h0, {31'h0, write_busy});
        end
        fetch(8'h12, 8'h5a);
        $display("t_keys done");
    endtask

    // Programmer reads and writes, blocked by either protection
    task automatic t_prog();
        prog(1'b0, 8'h12, 8'h00);
        chk("prog_read", 32'h5a, {24'h0, prd});
        chk("prog_ok", 32'h0, {31'h0, prf});
        protect_a <= 1'b1;
        prog(1'b0, 8'h12, 8'h00);
        chk("prog_read_blocked", 32'h0, {24'h0, prd});
        chk("prog_refused_a", 32'h1, {31'h0, prf});
        protect_a <= 1'b0;
        protect_b <= 1'b1;
        prog(1'b1, 8'h12, 8'h77);
        chk("prog_refused_b", 32'h1, {31'h0, prf});
        protect_b <= 1'b0;
        prog(1'b1, 8'h30, 8'h66);
        prog(1'b0, 8'h12, 8'h00);
        chk("prog_write_blocked", 32'h5a, {24'h0, prd});
        prog(1'b0, 8'h30, 8'h00);
        chk("prog_write", 32'h66, {24'h0, prd});
        fetch(8'h30, 8'h66);
        $display("t_prog done");
    endtask

    // Other reset during a write: registers clear, write aborts
    task automatic t_soft();
        commit(8'h20, 8'h11);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        @(posedge pclk);
        chk("abort_busy", 32'h0, {31'h0, write_busy});
        rdchk("ctrl_abort", `DNAC_OFF_CTRL, 8'h08);
        rdchk("location_soft", `DNAC_OFF_LOCATION, 8'h00);
        rdchk("byte_soft", `DNAC_OFF_BYTE, 8'h00);
        wr(`DNAC_OFF_CTRL, 8'h00);
        rdchk("abort_cleared", `DNAC_OFF_CTRL, 8'h00);
        // Soft reset keeps the space select and clears the option bit
        wr(`DNAC_OFF_CTRL, 8'h90);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        rdchk("ctrl_soft_kept", `DNAC_OFF_CTRL, 8'h80);
        wr(`DNAC_OFF_CTRL, 8'h00);
        $display("t_soft done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        soft_reset = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        protect_a = 1'b0;
        protect_b = 1'b0;
        prog_valid = 1'b0;
        prog_write = 1'b0;
        prog_addr = 8'h00;
        prog_wdata = 8'h00;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        busy_cyc = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_commit();
        t_keys();
        t_prog();
        t_soft();
        test_done();
    end
endmodule

`default_nettype wire
